// ---- verilog/timer_device.sv ----
// device end: comparators 3 and 4, stream trigger compare and interrupt flags
// assumes: host end on the same ref_clk drives reg_link_if.host; event_time
// and the mode inputs come from logic on ref_clk
// comparators 1 and 2 and the event timer itself live outside this block
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "event_timer_params.svh"

module timer_device (
    input wire logic ref_clk,
    input wire logic rst,
    reg_link_if.device link,
    input wire logic [`TIME_W-1:0] event_time,
    input wire logic stream_mode,
    input wire logic trig_enable,
    input wire logic compare2_disable,
    input wire logic [`DATA_W-1:0] irq_enable,
    input wire logic [`DATA_W-1:0] event_normal,
    input wire logic [`DATA_W-1:0] event_stream,
    output logic [`TIME_W-1:0] compare3_value,
    output logic compare3_disable,
    output logic [`TIME_W-1:0] compare4_value,
    output logic compare4_disable,
    output logic seq_start
);
    logic [`DATA_W-1:0] cmp3_high;
    logic [`DATA_W-1:0] cmp3_low;
    logic [`DATA_W-1:0] cmp4_high;
    logic [`DATA_W-1:0] cmp4_low;
    logic cmp3_hit;
    logic cmp4_hit;
    logic [`TRIG_W-1:0] stream_trigger_value;
    logic trig_match_q;
    logic trig_hit;
    logic [`DATA_W-1:0] flags_q;
    logic [`DATA_W-1:0] flags_d;
    logic [`DATA_W-1:0] flag_set;
    logic [`DATA_W-1:0] flag_clear;
    logic [`DATA_W-1:0] ext_events;
    logic [`DATA_W-1:0] read_word;
    logic [`DATA_W-1:0] rdata_q;

    logic wr_cmp3_high;
    logic wr_cmp3_low;
    logic wr_cmp4_high;
    logic wr_cmp4_low;
    logic wr_trig;
    logic rd_flags;
    logic trig_armed;
    logic trig_equal;
    logic cmp2_event;
    logic [`DATA_W-1:0] flag_pending;

    // the link carries one strobe a cycle, so at most one of these is high
    assign wr_cmp3_high = link.wr && link.addr == `REG_CMP3_HIGH;
    assign wr_cmp3_low = link.wr && link.addr == `REG_CMP3_LOW;
    assign wr_cmp4_high = link.wr && link.addr == `REG_CMP4_HIGH;
    assign wr_cmp4_low = link.wr && link.addr == `REG_CMP4_LOW;
    assign wr_trig = link.wr && link.addr == `REG_STREAM_TRIG;
    assign rd_flags = link.rd && link.addr == `REG_IRQ_FLAGS;

    // high strobe only stages; the low strobe loads the active comparator
    compare_unit cmp3 (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_high(wr_cmp3_high),
        .wr_low(wr_cmp3_low),
        .wdata(link.wdata),
        .event_time(event_time),
        .high_word(cmp3_high),
        .low_word(cmp3_low),
        .active_value(compare3_value),
        .active_disable(compare3_disable),
        .hit(cmp3_hit)
    );

    // same unit for comparator 4; only its decoded strobes differ
    compare_unit cmp4 (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_high(wr_cmp4_high),
        .wr_low(wr_cmp4_low),
        .wdata(link.wdata),
        .event_time(event_time),
        .high_word(cmp4_high),
        .low_word(cmp4_low),
        .active_value(compare4_value),
        .active_disable(compare4_disable),
        .hit(cmp4_hit)
    );

    // the trigger word is kept and compared in either mode; only stream mode turns a match into trig_hit
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            stream_trigger_value <= `TRIG_RST;
        else if (wr_trig)
            stream_trigger_value <= link.wdata;
    end

    // the match register tracks trig_equal every cycle in either mode; only trig_hit is gated by stream mode
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            trig_match_q <= 1'b0;
        else
            trig_match_q <= trig_equal;
    end

    // relies on the host keeping compare2_disable low and trig_enable high
    assign trig_armed = stream_mode
        && trig_enable && !compare2_disable;
    assign trig_equal = stream_trigger_value == event_time[`TRIG_W-1:0];
    assign trig_hit = trig_armed && trig_equal && !trig_match_q;

    // comparator 2 itself lives outside; in normal mode its event arrives as an input
    assign cmp2_event = stream_mode ? trig_hit : event_normal[`FLAG_CMP2];

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            seq_start <= 1'b0;
        else
            seq_start <= trig_hit;
    end

    // shared status bits take their source from the current mode
    always_comb
    begin
        ext_events = stream_mode ?
            ((event_normal & ~`FLAG_MUX_MASK) | (event_stream & `FLAG_MUX_MASK)) :
            event_normal;
        ext_events = ext_events & ~`FLAG_OWN_MASK;
    end

    always_comb
    begin
        flag_set = ext_events;
        flag_set[`FLAG_CMP2] = cmp2_event;
        flag_set[`FLAG_CMP3] = cmp3_hit;
        flag_set[`FLAG_CMP4] = cmp4_hit;
    end

    // a read clears only what it returned; a new event in that cycle survives
    assign flag_clear = rd_flags ? flags_q : '0;
    assign flags_d = (flags_q & ~flag_clear) | flag_set;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end

    // level request, held until a status read empties every enabled flag
    assign flag_pending = flags_q & irq_enable;
    assign link.irq = |flag_pending;

    always_comb
    begin
        unique case (link.addr)
            `REG_CMP3_HIGH: read_word = cmp3_high;
            `REG_CMP3_LOW: read_word = cmp3_low;
            `REG_CMP4_HIGH: read_word = cmp4_high;
            `REG_CMP4_LOW: read_word = cmp4_low;
            `REG_STREAM_TRIG: read_word = stream_trigger_value;
            `REG_IRQ_FLAGS: read_word = flags_q;
            default: read_word = '0;
        endcase
    end

    // read data stands for the one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rdata_q <= '0;
        else if (link.rd)
            rdata_q <= read_word;
        else
            rdata_q <= '0;
    end

    assign link.rdata = rdata_q;
endmodule

`default_nettype wire

// ---- verilog/event_timer_params.svh ----
// register map, field positions and reset values for the event timer compare bank
// assumes: included by bare name from the package, the modules and the sim files
`ifndef EVENT_TIMER_PARAMS_SVH
`define EVENT_TIMER_PARAMS_SVH

`define ADDR_W 8
`define DATA_W 16
`define TIME_W 24
`define TRIG_W 16

`define REG_CMP3_HIGH 8'h1F
`define REG_CMP3_LOW 8'h20
`define REG_CMP4_HIGH 8'h21
`define REG_CMP4_LOW 8'h22
`define REG_STREAM_TRIG 8'h23
`define REG_IRQ_FLAGS 8'h24
`define REG_HOST_CTRL 8'h80
`define REG_HOST_STAT 8'h81

`define HIGH_DIS_BIT 15
`define HIGH_UPPER_MSB 7
`define HIGH_MASK 16'h80FF
`define HIGH_RST 16'h00FF
`define LOW_RST 16'hFFFF
`define VALUE_RST 24'hFFFFFF
`define TRIG_RST 16'hFFFF

`define FLAG_CMP2 8
`define FLAG_CMP3 9
`define FLAG_CMP4 10
`define FLAG_OWN_MASK 16'h0700
`define FLAG_MUX_MASK 16'h60C0

`define HOST_START_BIT 0
`define HOST_IRQ_BIT 0
`define HOST_BUSY_BIT 1
`define HOST_DONE_BIT 2
`define INIT_HIGH_WORD 16'h80FF
`define INIT_LOW_WORD 16'hFFFF

`endif

// ---- verilog/event_timer_pkg.sv ----
// types shared by the compare bank device end and its host end
// assumes: event_timer_params.svh is on the include path
`include "event_timer_params.svh"

package event_timer_pkg;
    typedef logic [`ADDR_W-1:0] reg_addr_t;
    typedef logic [`DATA_W-1:0] reg_word_t;
    typedef logic [`TIME_W-1:0] time_value_t;

    typedef enum logic [4:0] {
        HOST_IDLE = 5'b00001,
        HOST_INIT_H3 = 5'b00010,
        HOST_INIT_L3 = 5'b00100,
        HOST_INIT_H4 = 5'b01000,
        HOST_INIT_L4 = 5'b10000
    } host_state_t;
endpackage

// ---- verilog/reg_link_if.sv ----
// register access link between the host controller and the compare bank
// assumes: both ends run on the same ref_clk; one access per cycle at most
`timescale 1ns/10ps
`default_nettype none

interface reg_link_if;
    event_timer_pkg::reg_addr_t addr;
    event_timer_pkg::reg_word_t wdata;
    logic wr;
    logic rd;
    event_timer_pkg::reg_word_t rdata;
    logic irq;

    modport device (input addr, input wdata, input wr, input rd, output rdata, output irq);
    modport host (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface

`default_nettype wire

// ---- verilog/compare_unit.sv ----
// one 24-bit absolute time comparator with its staged high word and low word
// assumes: wr_high and wr_low are single-cycle strobes, never in the same cycle
`timescale 1ns/10ps
`default_nettype none
`include "event_timer_params.svh"

module compare_unit (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_high,
    input wire logic wr_low,
    input wire logic [`DATA_W-1:0] wdata,
    input wire logic [`TIME_W-1:0] event_time,
    output logic [`DATA_W-1:0] high_word,
    output logic [`DATA_W-1:0] low_word,
    output logic [`TIME_W-1:0] active_value,
    output logic active_disable,
    output logic hit
);
    logic match_q;

    // reserved bits are not stored, so they read back as zero
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            high_word <= `HIGH_RST;
        else if (wr_high)
            high_word <= wdata & `HIGH_MASK;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            low_word <= `LOW_RST;
        else if (wr_low)
            low_word <= wdata;
    end

    // staged high word only takes effect with the low-word write
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            active_value <= `VALUE_RST;
            active_disable <= 1'b0;
        end
        else if (wr_low)
        begin
            active_value <= {high_word[`HIGH_UPPER_MSB:0], wdata};
            active_disable <= high_word[`HIGH_DIS_BIT];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            match_q <= 1'b0;
        else
            match_q <= (active_value == event_time);
    end

    // first cycle of equality only, so a stalled timer sets the flag once
    assign hit = (active_value == event_time) && !match_q && !active_disable;
endmodule

`default_nettype wire

// ---- verilog/timer_host.sv ----
// host end: forwards software accesses to the link and runs a start-up sequence
// assumes: software port on ref_clk, strobes one cycle, never both at once
`timescale 1ns/10ps
`default_nettype none
`include "event_timer_params.svh"

module timer_host (
    input wire logic ref_clk,
    input wire logic rst,
    reg_link_if.host link,
    input wire logic [`ADDR_W-1:0] sw_addr,
    input wire logic [`DATA_W-1:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [`DATA_W-1:0] sw_rdata,
    output logic irq_out
);
    event_timer_pkg::host_state_t state_q;
    event_timer_pkg::host_state_t state_d;
    logic local_hit;
    logic start;
    logic done_q;
    logic local_sel_q;
    logic [`DATA_W-1:0] local_rdata_q;

    assign local_hit = (sw_addr == `REG_HOST_CTRL) || (sw_addr == `REG_HOST_STAT);
    assign start = sw_wr && sw_addr == `REG_HOST_CTRL && sw_wdata[`HOST_START_BIT]
        && state_q == event_timer_pkg::HOST_IDLE;

    // start-up writes the disable bit high before each low word load
    always_comb
    begin
        unique case (state_q)
            event_timer_pkg::HOST_IDLE:
                state_d = start ? event_timer_pkg::HOST_INIT_H3 : event_timer_pkg::HOST_IDLE;
            event_timer_pkg::HOST_INIT_H3: state_d = event_timer_pkg::HOST_INIT_L3;
            event_timer_pkg::HOST_INIT_L3: state_d = event_timer_pkg::HOST_INIT_H4;
            event_timer_pkg::HOST_INIT_H4: state_d = event_timer_pkg::HOST_INIT_L4;
            event_timer_pkg::HOST_INIT_L4: state_d = event_timer_pkg::HOST_IDLE;
            default: state_d = event_timer_pkg::HOST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            state_q <= event_timer_pkg::HOST_IDLE;
        else
            state_q <= state_d;
    end

    // software link accesses are dropped while the start-up sequence runs
    always_comb
    begin
        link.addr = sw_addr;
        link.wdata = sw_wdata;
        link.wr = 1'b0;
        link.rd = 1'b0;
        unique case (state_q)
            event_timer_pkg::HOST_IDLE:
            begin
                link.wr = sw_wr && !local_hit;
                link.rd = sw_rd && !local_hit;
            end
            event_timer_pkg::HOST_INIT_H3:
            begin
                link.addr = `REG_CMP3_HIGH;
                link.wdata = `INIT_HIGH_WORD;
                link.wr = 1'b1;
            end
            event_timer_pkg::HOST_INIT_L3:
            begin
                link.addr = `REG_CMP3_LOW;
                link.wdata = `INIT_LOW_WORD;
                link.wr = 1'b1;
            end
            event_timer_pkg::HOST_INIT_H4:
            begin
                link.addr = `REG_CMP4_HIGH;
                link.wdata = `INIT_HIGH_WORD;
                link.wr = 1'b1;
            end
            event_timer_pkg::HOST_INIT_L4:
            begin
                link.addr = `REG_CMP4_LOW;
                link.wdata = `INIT_LOW_WORD;
                link.wr = 1'b1;
            end
            default:
            begin
                link.wr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            done_q <= 1'b0;
        else if (state_q == event_timer_pkg::HOST_INIT_L4)
            done_q <= 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            local_sel_q <= 1'b0;
            local_rdata_q <= '0;
        end
        else
        begin
            local_sel_q <= sw_rd && local_hit;
            local_rdata_q <= '0;
            if (sw_rd && sw_addr == `REG_HOST_STAT)
            begin
                local_rdata_q[`HOST_IRQ_BIT] <= link.irq;
                local_rdata_q[`HOST_BUSY_BIT] <= state_q != event_timer_pkg::HOST_IDLE;
                local_rdata_q[`HOST_DONE_BIT] <= done_q;
            end
        end
    end

    assign sw_rdata = local_sel_q ? local_rdata_q : link.rdata;
    assign irq_out = link.irq;
endmodule

`default_nettype wire

// ---- sim/event_timer_chk.sv ----
// register link assertions for the compare bank: readback, reserved bits, idle data
// assumes: instantiated beside reg_link_if in the testbench, all on ref_clk
`include "event_timer_params.svh"
`timescale 1ns/10ps
`default_nettype none

module event_timer_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire event_timer_pkg::reg_addr_t addr,
    input wire event_timer_pkg::reg_word_t wdata,
    input wire logic wr,
    input wire logic rd,
    input wire event_timer_pkg::reg_word_t rdata,
    input wire logic irq
);
    // shadow of what the stored words must read back as
    logic [15:0] shadow_q [0:4];
    logic [2:0] idx;
    logic is_high;
    assign idx = 3'(addr - 8'h1F);
    assign is_high = (addr == 8'h1F) || (addr == 8'h21);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            shadow_q[0] <= 16'h00FF;
            shadow_q[1] <= 16'hFFFF;
            shadow_q[2] <= 16'h00FF;
            shadow_q[3] <= 16'hFFFF;
            shadow_q[4] <= 16'hFFFF;
        end
        else if (wr && addr >= 8'h1F && addr <= 8'h23)
        begin
            shadow_q[idx] <= is_high ? (wdata & 16'h80FF) : wdata;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    rdata_idle_a: assert property (!rd |=> rdata == 16'h0000)
        else $error("read data not zero outside a read");
    unmapped_rd_a: assert property (rd && (addr < 8'h1F || addr > 8'h24) |=> rdata == 16'h0000)
        else $error("unmapped read returned data");
    cmp3_high_a: assert property (rd && addr == 8'h1F |=> rdata == shadow_q[0])
        else $error("comparator 3 high word readback wrong");
    cmp3_low_a: assert property (rd && addr == 8'h20 |=> rdata == shadow_q[1])
        else $error("comparator 3 low word readback wrong");
    cmp4_high_a: assert property (rd && addr == 8'h21 |=> rdata == shadow_q[2])
        else $error("comparator 4 high word readback wrong");
    cmp4_low_a: assert property (rd && addr == 8'h22 |=> rdata == shadow_q[3])
        else $error("comparator 4 low word readback wrong");
    trig_reg_a: assert property (rd && addr == 8'h23 |=> rdata == shadow_q[4])
        else $error("stream trigger readback wrong");
    resv_bits_a: assert property (rd && is_high |=> rdata[14:8] == 7'h00)
        else $error("reserved high word bits read nonzero");

    cover property (wr && addr == 8'h22);
    cover property (rd && addr == 8'h24 ##1 rdata != 16'h0000);
    cover property ($rose(irq));
endmodule

`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench: host end and device end joined by reg_link_if
// assumes: design package, interface and modules compiled before this file
`include "event_timer_params.svh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic ref_clk;
    logic rst;
    logic [7:0] sw_addr;
    logic [15:0] sw_wdata;
    logic sw_wr;
    logic sw_rd;
    logic [15:0] sw_rdata;
    logic irq_out;
    logic [23:0] event_time;
    logic stream_mode;
    logic trig_enable;
    logic [15:0] irq_enable;
    logic [15:0] event_stream;
    logic [15:0] event_normal;
    logic compare2_disable;
    logic [23:0] compare3_value;
    logic compare3_disable;
    logic [23:0] compare4_value;
    logic compare4_disable;
    logic seq_start;
    int fail_count;
    int n_tests;
    int cycles;
    logic [15:0] d;
    int n;

    reg_link_if link_if ();
    timer_device timer_device_inst (.ref_clk(ref_clk), .rst(rst), .link(link_if.device),
        .event_time(event_time), .stream_mode(stream_mode), .trig_enable(trig_enable),
        .compare2_disable(compare2_disable), .irq_enable(irq_enable),
        .event_normal(event_normal),
        .event_stream(event_stream), .compare3_value(compare3_value),
        .compare3_disable(compare3_disable), .compare4_value(compare4_value),
        .compare4_disable(compare4_disable), .seq_start(seq_start));
    timer_host timer_host_inst (.ref_clk(ref_clk), .rst(rst), .link(link_if.host),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .irq_out(irq_out));
    event_timer_chk event_timer_chk_inst (.ref_clk(ref_clk), .rst(rst), .addr(link_if.addr),
        .wdata(link_if.wdata), .wr(link_if.wr), .rd(link_if.rd), .rdata(link_if.rdata),
        .irq(link_if.irq));

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            final_report();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_wdata <= v;
        sw_wr <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        #1;
        v = sw_rdata;
    endtask

    task automatic set_time(input logic [23:0] t);
        @(posedge ref_clk);
        event_time <= t;
    endtask

    // seq_start is a one-cycle pulse, so look after every edge
    task automatic count_starts(output int k);
        k = 0;
        repeat (6)
        begin
            tick(1);
            if (seq_start === 1'b1)
                k++;
        end
    endtask

    task automatic t_reset();
        logic [15:0] exp [0:6];
        logic [7:0] adr [0:6];
        exp = '{16'h00FF, 16'hFFFF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000};
        adr = '{8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30};
        for (int i = 0; i < 7; i++)
        begin
            rd_reg(adr[i], d);
            check("reset word", d, exp[i]);
        end
        check("c3 value", compare3_value, 24'hFFFFFF);
        check("c4 value", compare4_value, 24'hFFFFFF);
        check("c3 dis", compare3_disable, 1'b0);
        check("c4 dis", compare4_disable, 1'b0);
    endtask

    task automatic t_init();
        wr_reg(8'h80, 16'h0001);
        tick(8);
        check("init c3 dis", compare3_disable, 1'b1);
        check("init c4 dis", compare4_disable, 1'b1);
        rd_reg(8'h81, d);
        check("init done", d[2], 1'b1);
    endtask

    task automatic t_cmp4();
        wr_reg(8'h21, 16'h7F12);
        tick(2);
        check("c4 staged value", compare4_value, 24'hFFFFFF);
        check("c4 staged dis", compare4_disable, 1'b1);
        rd_reg(8'h21, d);
        check("c4 high word", d, 16'h0012);
        wr_reg(8'h22, 16'h3456);
        tick(2);
        check("c4 loaded", compare4_value, 24'h123456);
        check("c4 enabled", compare4_disable, 1'b0);
        set_time(24'h123456);
        tick(3);
        rd_reg(8'h24, d);
        check("c4 flag", d, 16'h0400);
        wr_reg(8'h21, 16'h8034);
        wr_reg(8'h22, 16'h0001);
        wr_reg(8'h22, 16'h0002);
        tick(2);
        check("c4 lone low", compare4_value, 24'h340002);
        check("c4 disabled", compare4_disable, 1'b1);
    endtask

    task automatic t_cmp3();
        wr_reg(8'h1F, 16'h0034);
        wr_reg(8'h20, 16'h5678);
        tick(2);
        check("c3 loaded", compare3_value, 24'h345678);
        check("c3 enabled", compare3_disable, 1'b0);
        @(posedge ref_clk);
        irq_enable <= 16'h0200;
        set_time(24'h345678);
        tick(4);
        check("irq raised", irq_out, 1'b1);
        rd_reg(8'h24, d);
        check("c3 flag", d, 16'h0200);
        tick(1);
        check("irq released", irq_out, 1'b0);
        wr_reg(8'h1F, 16'h8034);
        wr_reg(8'h20, 16'h5679);
        tick(2);
        set_time(24'h345679);
        tick(3);
        set_time(24'h340002);
        tick(4);
        rd_reg(8'h24, d);
        check("disabled no flag", d, 16'h0000);
        check("no irq", irq_out, 1'b0);
    endtask

    task automatic t_stream();
        @(posedge ref_clk);
        irq_enable <= 16'h0000;
        stream_mode <= 1'b1;
        trig_enable <= 1'b1;
        wr_reg(8'h23, 16'hABCD);
        set_time(24'h00ABCD);
        count_starts(n);
        check("stream start", n, 1);
        check("masked irq", irq_out, 1'b0);
        @(posedge ref_clk);
        irq_enable <= 16'h0100;
        tick(1);
        check("c2 irq", irq_out, 1'b1);
        rd_reg(8'h24, d);
        check("c2 flag", d, 16'h0100);
        @(posedge ref_clk);
        compare2_disable <= 1'b1;
        set_time(24'h000000);
        set_time(24'h00ABCD);
        count_starts(n);
        check("c2 disabled no start", n, 0);
        @(posedge ref_clk);
        compare2_disable <= 1'b0;
        @(posedge ref_clk);
        event_stream <= 16'h60C0;
        @(posedge ref_clk);
        event_stream <= 16'h0000;
        tick(2);
        rd_reg(8'h24, d);
        check("muxed flags", d, 16'h60C0);
        @(posedge ref_clk);
        stream_mode <= 1'b0;
        set_time(24'h000000);
        set_time(24'h00ABCD);
        count_starts(n);
        check("normal no start", n, 0);
        rd_reg(8'h24, d);
        check("normal no flag", d, 16'h0000);
        @(posedge ref_clk);
        event_normal <= 16'h07C0;
        event_stream <= 16'h6000;
        @(posedge ref_clk);
        event_normal <= 16'h0000;
        event_stream <= 16'h0000;
        tick(2);
        rd_reg(8'h24, d);
        check("normal muxed flags", d, 16'h01C0);
    endtask

    initial
    begin
        rst = 1'b1;
        sw_addr = 8'h00;
        sw_wdata = 16'h0000;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        event_time = 24'h000000;
        stream_mode = 1'b0;
        trig_enable = 1'b0;
        irq_enable = 16'h0000;
        event_stream = 16'h0000;
        event_normal = 16'h0000;
        compare2_disable = 1'b0;
        fail_count = 0;
        n_tests = 0;
        cycles = 0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_init();
        t_cmp4();
        t_cmp3();
        t_stream();
        final_report();
    end
endmodule

`default_nettype wire
